// ===== core/brte_core.sv
`timescale 1ns/10ps
// Operation
// R1 - Control scan puts control register in path; capture leaves it unchanged.
// R2 - Controller loads control register by scan before run-test instruction.
// R3 - Bits 2..0: X00 sample/toggle, X01 pattern16, X10 signature16.
// R4 - 011 signature8 with pattern8; 111 signature8 with binary count.
// R5 - Operation runs only with run-test instruction in Run-Test/Idle.
// R6 - Control cells 35-32 excluded; enable cells 35-34 still steer outputs.
// R7 - Operations only when direction enables differ; otherwise bypass.
// R8 - Bits 10..3 mask inputs 8..1 of the active source bus.
// R9 - Mask bit zero includes input; set mask bit ignores it. Sample/toggle applies no mask and captures every pin of the source bus.
// R10 - Sample/toggle captures selected input pins, then updates input shadows.
// R11 - Sample/toggle inverts output cells, shadows and pins on falling edge.
// R12 - Pattern16 steps 16-bit LFSR; outputs and core inputs get values.
// R13 - All-zero seed stays all zero in pattern generators.
// R14 - Controller should scan a seed into cell chain before running.
// R15 - Signature16 compresses selected inputs; core gets values via shadows.
// R16 - During signature16 output shadows hold and keep driving outputs.
// R17 - Both 8-bit modes compress inputs into 8-bit input-cell signature.
// R18 - Signature-pattern mode steps 8-bit output LFSR; pins on falling edge.
// R19 - Signature-count mode counts output cells up; pins on falling edge.
// R20 - Opposite output cells count carries, extending the count to 16.
// R21 - Run-test code 00001001 runs control-register operation in idle.
// R22 - Inputs taken on rising test clock, outputs change on falling edge.
// R23 - LFSR tap positions are parameters per mode and direction.
// R24 - Source bus follows enables: A disabled, B enabled means A to B.
module brte_core #(
    // R23 taps as parameters
    parameter logic [15:0] TAP16_PAT_AB = brte_pkg::TAP16_DEFAULT,
    parameter logic [15:0] TAP16_PAT_BA = brte_pkg::TAP16_DEFAULT,
    parameter logic [15:0] TAP16_SIG_AB = brte_pkg::TAP16_DEFAULT,
    parameter logic [15:0] TAP16_SIG_BA = brte_pkg::TAP16_DEFAULT,
    parameter logic [7:0] TAP8_SIG_AB = brte_pkg::TAP8_DEFAULT,
    parameter logic [7:0] TAP8_SIG_BA = brte_pkg::TAP8_DEFAULT,
    parameter logic [7:0] TAP8_PAT_AB = brte_pkg::TAP8_DEFAULT,
    parameter logic [7:0] TAP8_PAT_BA = brte_pkg::TAP8_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tck,
    input wire brte_pkg::brte_tap_s tap,
    input wire logic chain_scan_sel,
    input wire logic [7:0] a_pin_i,
    input wire logic [7:0] b_pin_i,
    output logic [7:0] a_pin_o,
    output logic a_pin_oe,
    output logic [7:0] b_pin_o,
    output logic b_pin_oe,
    output logic [7:0] core_a_o,
    output logic [7:0] core_b_o,
    output logic tdo_o,
    output logic run_active_o,
    output logic ctrl_update_o
);

    // Test clock domain state
    logic ce_meta_ff;
    logic ce_tck_ff;
    logic [7:0] a_meta_ff;
    logic [7:0] a_pin_ff;
    logic [7:0] b_meta_ff;
    logic [7:0] b_pin_ff;
    logic [10:0] ctrl_shift_ff;
    logic [10:0] ctrl_ff;
    brte_pkg::brte_cells_s cells_ff;
    brte_pkg::brte_cells_s nxt_cells;
    logic upd_tgl_ff;
    logic run_tck_ff;

    // Falling edge state
    logic [7:0] a_out_sh_ff;
    logic [7:0] b_out_sh_ff;
    logic a_oe_sh_ff;
    logic b_oe_sh_ff;
    logic [7:0] core_a_ff;
    logic [7:0] core_b_ff;
    logic tdo_ff;

    // System clock domain state
    logic run_meta_ff;
    logic run_sys_ff;
    logic upd_meta_ff;
    logic upd_s2_ff;
    logic upd_s3_ff;
    logic upd_pulse_ff;

    logic ctrl_sel;
    logic dir_ab;
    logic dir_valid;
    logic run_now;
    logic drive_outs;
    brte_pkg::brte_op_e op;
    logic [7:0] mask;
    logic [7:0] src_pins;
    logic [7:0] src_in;
    logic [7:0] dst_out;
    logic [7:0] opp_out;
    logic [15:0] pair16;
    logic [15:0] tap16_pat;
    logic [15:0] tap16_sig;
    logic [7:0] tap8_sig;
    logic [7:0] tap8_pat;

    // R1 control scan select
    assign ctrl_sel = (tap.instr == brte_pkg::INSTR_CTRL_SCAN_NORMAL) ||
                      (tap.instr == brte_pkg::INSTR_CTRL_SCAN_TEST);

    // R24 direction from enable cells
    assign dir_ab = cells_ff.ctl[brte_pkg::CTL_A_EN_N] &
                    ~cells_ff.ctl[brte_pkg::CTL_B_EN_N];
    // R7 equal enables fall back to bypass
    assign dir_valid = cells_ff.ctl[brte_pkg::CTL_A_EN_N] ^
                       cells_ff.ctl[brte_pkg::CTL_B_EN_N];
    // R5 R21 run gate
    assign run_now = (tap.instr == brte_pkg::INSTR_RUN_TEST) &&
                     tap.run_idle && dir_valid;

    // R3 R4 opcode decode
    assign op = brte_pkg::decode_op(ctrl_ff[brte_pkg::OP_LSB +: brte_pkg::OP_W]);
    assign mask = ctrl_ff[brte_pkg::MASK_LSB +: brte_pkg::MASK_W];

    // R16 signature16 leaves output shadows alone
    assign drive_outs = run_tck_ff && (op != brte_pkg::OP_SIGNATURE16) &&
                        (op != brte_pkg::OP_NONE);

    assign src_pins = dir_ab ? a_pin_ff : b_pin_ff;
    assign src_in = dir_ab ? cells_ff.a_in : cells_ff.b_in;
    assign dst_out = dir_ab ? cells_ff.b_out : cells_ff.a_out;
    assign opp_out = dir_ab ? cells_ff.a_out : cells_ff.b_out;
    assign tap16_pat = dir_ab ? TAP16_PAT_AB : TAP16_PAT_BA;
    assign tap16_sig = dir_ab ? TAP16_SIG_AB : TAP16_SIG_BA;
    assign tap8_sig = dir_ab ? TAP8_SIG_AB : TAP8_SIG_BA;
    assign tap8_pat = dir_ab ? TAP8_PAT_AB : TAP8_PAT_BA;

    // Next cell values for one run-test step
    always_comb begin
        logic [7:0] n_in;
        logic [7:0] n_out;
        logic [7:0] n_opp;
        logic [7:0] data;
        n_in = src_in;
        n_out = dst_out;
        n_opp = opp_out;
        pair16 = 16'h0000;
        // R8 R9 masked inputs drop out of compression
        data = src_pins & ~mask;
        case (op)
            brte_pkg::OP_SAMPLE_TOGGLE: begin
                // R10 sample all selected pins, mask not applied
                n_in = src_pins;
                // R11 invert output cells
                n_out = ~dst_out;
            end
            brte_pkg::OP_PATTERN16: begin
                // R12 R13 16-bit pattern
                pair16 = brte_pkg::lfsr16({src_in, dst_out}, tap16_pat);
                n_in = pair16[15:8];
                n_out = pair16[7:0];
            end
            brte_pkg::OP_SIGNATURE16: begin
                // R15 16-bit signature
                pair16 = brte_pkg::lfsr16({src_in, dst_out}, tap16_sig) ^
                         {data, 8'h00};
                n_in = pair16[15:8];
                n_out = pair16[7:0];
            end
            brte_pkg::OP_SIG_PATTERN8: begin
                // R17 8-bit signature
                n_in = brte_pkg::lfsr8(src_in, tap8_sig) ^ data;
                // R18 R13 8-bit pattern
                n_out = brte_pkg::lfsr8(dst_out, tap8_pat);
            end
            brte_pkg::OP_SIG_COUNT8: begin
                // R17 8-bit signature
                n_in = brte_pkg::lfsr8(src_in, tap8_sig) ^ data;
                // R19 binary count up
                n_out = dst_out + 8'h01;
                // R20 carry into opposite cells
                if (dst_out == brte_pkg::BYTE_ALL_ONES) begin
                    n_opp = opp_out + 8'h01;
                end
            end
            default: begin
                n_in = src_in;
            end
        endcase
        // R6 control cells never take part
        nxt_cells.ctl = cells_ff.ctl;
        nxt_cells.a_in = dir_ab ? n_in : cells_ff.a_in;
        nxt_cells.b_in = dir_ab ? cells_ff.b_in : n_in;
        nxt_cells.b_out = dir_ab ? n_out : cells_ff.b_out;
        nxt_cells.a_out = dir_ab ? n_opp : n_out;
        if (!dir_ab) begin
            nxt_cells.b_out = n_opp;
        end
    end

    // Clock enable enters the test domain through two flops
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ce_meta_ff <= 1'b0;
            ce_tck_ff <= 1'b0;
        end else begin
            ce_meta_ff <= ce;
            ce_tck_ff <= ce_meta_ff;
        end
    end

    // R22 pins sampled on rising edge, two stages
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            a_meta_ff <= 8'h00;
            a_pin_ff <= 8'h00;
            b_meta_ff <= 8'h00;
            b_pin_ff <= 8'h00;
        end else if (ce_tck_ff) begin
            a_meta_ff <= a_pin_i;
            a_pin_ff <= a_meta_ff;
            b_meta_ff <= b_pin_i;
            b_pin_ff <= b_meta_ff;
        end
    end

    // Control register scan and update
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_shift_ff <= brte_pkg::CTRL_RESET;
            ctrl_ff <= brte_pkg::CTRL_RESET;
            upd_tgl_ff <= 1'b0;
        end else if (ce_tck_ff && ctrl_sel) begin
            // R1 capture leaves contents as they are
            if (tap.shift_dr) begin
                ctrl_shift_ff <= {tap.tdi, ctrl_shift_ff[10:1]};
            end
            if (tap.update_dr) begin
                ctrl_ff <= ctrl_shift_ff;
                upd_tgl_ff <= ~upd_tgl_ff;
            end
        end
    end

    // Cell chain: seed scan or run-test step
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            cells_ff <= brte_pkg::CELLS_RESET;
            run_tck_ff <= 1'b0;
        end else if (ce_tck_ff) begin
            run_tck_ff <= run_now;
            if (chain_scan_sel && tap.shift_dr) begin
                cells_ff <= {tap.tdi, cells_ff[35:1]};
            end else if (run_now) begin
                cells_ff <= nxt_cells;
            end
        end
    end

    // R22 outputs move on the falling edge
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            a_out_sh_ff <= 8'h00;
            b_out_sh_ff <= 8'h00;
            a_oe_sh_ff <= 1'b0;
            b_oe_sh_ff <= 1'b0;
        end else if (ce_tck_ff) begin
            // R6 enable cells drive pin state
            a_oe_sh_ff <= ~cells_ff.ctl[brte_pkg::CTL_A_EN_N];
            b_oe_sh_ff <= ~cells_ff.ctl[brte_pkg::CTL_B_EN_N];
            // R11 R12 R18 R19 output shadows follow cells
            if (drive_outs) begin
                a_out_sh_ff <= cells_ff.a_out;
                b_out_sh_ff <= cells_ff.b_out;
            end
        end
    end

    // Input shadows feed the core
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            core_a_ff <= 8'h00;
            core_b_ff <= 8'h00;
        end else if (ce_tck_ff && run_tck_ff && (op != brte_pkg::OP_NONE)) begin
            // R10 R12 R15 R17 input shadow update
            core_a_ff <= cells_ff.a_in;
            core_b_ff <= cells_ff.b_in;
        end
    end

    // Serial out changes on the falling edge
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_ff <= 1'b0;
        end else if (ce_tck_ff) begin
            tdo_ff <= ctrl_sel ? ctrl_shift_ff[0] : cells_ff[0];
        end
    end

    // Run level and update event cross to the system clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_meta_ff <= 1'b0;
            run_sys_ff <= 1'b0;
            upd_meta_ff <= 1'b0;
            upd_s2_ff <= 1'b0;
            upd_s3_ff <= 1'b0;
            upd_pulse_ff <= 1'b0;
        end else if (ce) begin
            run_meta_ff <= run_tck_ff;
            run_sys_ff <= run_meta_ff;
            upd_meta_ff <= upd_tgl_ff;
            upd_s2_ff <= upd_meta_ff;
            upd_s3_ff <= upd_s2_ff;
            upd_pulse_ff <= upd_s2_ff ^ upd_s3_ff;
        end
    end

    assign a_pin_o = a_out_sh_ff;
    assign b_pin_o = b_out_sh_ff;
    assign a_pin_oe = a_oe_sh_ff;
    assign b_pin_oe = b_oe_sh_ff;
    assign core_a_o = core_a_ff;
    assign core_b_o = core_b_ff;
    assign tdo_o = tdo_ff;
    assign run_active_o = run_sys_ff;
    assign ctrl_update_o = upd_pulse_ff;

endmodule : brte_core

// ===== core/brte_pkg.sv
package brte_pkg;

    // Test operation control register layout
    localparam int CTRL_W = 11;
    localparam int OP_LSB = 0;
    localparam int OP_W = 3;
    localparam int MASK_LSB = 3;
    localparam int MASK_W = 8;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    // Opcode values in bits 2..0
    localparam logic [1:0] OPL_SAMPLE_TOGGLE = 2'h0;
    localparam logic [1:0] OPL_PATTERN16 = 2'h1;
    localparam logic [1:0] OPL_SIGNATURE16 = 2'h2;
    localparam logic [2:0] OPC_SIG_PATTERN8 = 3'h3;
    localparam logic [2:0] OPC_SIG_COUNT8 = 3'h7;

    // Instruction register codes seen by this block
    localparam logic [7:0] INSTR_RUN_TEST = 8'h09;
    localparam logic [7:0] INSTR_CTRL_SCAN_NORMAL = 8'h8e;
    localparam logic [7:0] INSTR_CTRL_SCAN_TEST = 8'h0f;

    // Boundary cell chain
    localparam int CHAIN_W = 36;
    localparam int CTL_A_EN_N = 3;
    localparam int CTL_B_EN_N = 2;
    localparam logic [35:0] CELLS_RESET = 36'h0_0000_0000;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

    // Default feedback taps, overridable per instance
    localparam logic [15:0] TAP16_DEFAULT = 16'hb400;
    localparam logic [7:0] TAP8_DEFAULT = 8'hb8;

    // Chain order: control cells at the top, bit 0 shifts out first
    typedef struct packed {
        logic [3:0] ctl;
        logic [7:0] a_in;
        logic [7:0] b_in;
        logic [7:0] a_out;
        logic [7:0] b_out;
    } brte_cells_s;

    typedef struct packed {
        logic [7:0] instr;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
        logic run_idle;
        logic tdi;
    } brte_tap_s;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SAMPLE_TOGGLE,
        OP_PATTERN16,
        OP_SIGNATURE16,
        OP_SIG_PATTERN8,
        OP_SIG_COUNT8
    } brte_op_e;

    // Xor-only feedback: an all-zero state stays all zero
    function automatic logic [15:0] lfsr16(input logic [15:0] v,
                                           input logic [15:0] taps);
        lfsr16 = {v[14:0], ^(v & taps)};
    endfunction : lfsr16

    function automatic logic [7:0] lfsr8(input logic [7:0] v,
                                         input logic [7:0] taps);
        lfsr8 = {v[6:0], ^(v & taps)};
    endfunction : lfsr8

    function automatic brte_op_e decode_op(input logic [2:0] opc);
        if (opc == OPC_SIG_PATTERN8) begin
            decode_op = OP_SIG_PATTERN8;
        end else if (opc == OPC_SIG_COUNT8) begin
            decode_op = OP_SIG_COUNT8;
        end else if (opc[1:0] == OPL_SAMPLE_TOGGLE) begin
            decode_op = OP_SAMPLE_TOGGLE;
        end else if (opc[1:0] == OPL_PATTERN16) begin
            decode_op = OP_PATTERN16;
        end else if (opc[1:0] == OPL_SIGNATURE16) begin
            decode_op = OP_SIGNATURE16;
        end else begin
            decode_op = OP_NONE;
        end
    endfunction : decode_op

endpackage : brte_pkg

// ===== sim/brte_core_asserts.sv
`timescale 1ns/10ps
module brte_core_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tck,
    input wire brte_pkg::brte_tap_s tap,
    input wire logic chain_scan_sel,
    input wire logic [7:0] a_pin_i,
    input wire logic [7:0] b_pin_i,
    input wire logic [7:0] a_pin_o,
    input wire logic a_pin_oe,
    input wire logic [7:0] b_pin_o,
    input wire logic b_pin_oe,
    input wire logic [7:0] core_a_o,
    input wire logic [7:0] core_b_o,
    input wire logic tdo_o,
    input wire logic run_active_o,
    input wire logic ctrl_update_o
);
    logic upd_tg_ff;
    logic [3:0] live_ff;
    wire logic step = tap.instr == brte_pkg::INSTR_RUN_TEST && tap.run_idle;
    wire logic ctrl_sel = tap.instr == brte_pkg::INSTR_CTRL_SCAN_NORMAL ||
        tap.instr == brte_pkg::INSTR_CTRL_SCAN_TEST;
    // Startup oe settling is ignored for a few edges
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            live_ff <= 4'h0;
            upd_tg_ff <= 1'b0;
        end else begin
            live_ff <= {live_ff[2:0], 1'b1};
            if (tap.update_dr && ctrl_sel) begin
                upd_tg_ff <= ~upd_tg_ff;
            end
        end
    end
    upd_pulse_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl_update_o |=> !ctrl_update_o) else $error("update pulse long");
    upd_follow_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(upd_tg_ff) |-> ##[0:8] ctrl_update_o) else $error("no update");
    run_instr_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n) run_active_o |->
        tap.instr == brte_pkg::INSTR_RUN_TEST) else $error("run wrong instr");
    run_stop_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!tap.run_idle) [*6] |-> !run_active_o) else $error("run not stopped");
    pin_hold_a: assert property (
        @(posedge tck) disable iff (!rst_n) live_ff[3] && ($changed(a_pin_o)
        || $changed(b_pin_o)) |-> $past(step)) else $error("pins moved");
    core_hold_a: assert property (
        @(posedge tck) disable iff (!rst_n) live_ff[3] && ($changed(core_a_o)
        || $changed(core_b_o)) |-> $past(step)) else $error("core moved");
    oe_hold_a: assert property (
        @(posedge tck) disable iff (!rst_n) live_ff[3] && ($changed(a_pin_oe)
        || $changed(b_pin_oe)) |-> $past(tap.shift_dr || tap.update_dr))
        else $error("oe moved");
    tdo_move_a: assert property (
        @(posedge tck) disable iff (!rst_n) live_ff[3] && $changed(tdo_o) |->
        $past(tap.shift_dr || step) || $past(tap.instr) != $past(tap.instr, 2))
        else $error("tdo moved");
    cover property (@(posedge clk_sys) $rose(run_active_o));
    cover property (@(posedge clk_sys) ctrl_update_o);
    cover property (@(posedge tck) $changed(b_pin_o));
endmodule : brte_core_asserts

bind brte_core brte_core_asserts chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .ce(ce), .tck(tck), .tap(tap), .chain_scan_sel(chain_scan_sel),
    .a_pin_i(a_pin_i), .b_pin_i(b_pin_i), .a_pin_o(a_pin_o),
    .a_pin_oe(a_pin_oe), .b_pin_o(b_pin_o), .b_pin_oe(b_pin_oe),
    .core_a_o(core_a_o), .core_b_o(core_b_o), .tdo_o(tdo_o),
    .run_active_o(run_active_o), .ctrl_update_o(ctrl_update_o));

// ===== sim/brte_ctlr_model.sv
`timescale 1ns/10ps
module brte_ctlr_model (
    output logic tck,
    output brte_pkg::brte_tap_s tap,
    output logic chain_scan_sel,
    input wire logic tdo_o
);
    initial begin
        tck = 1'b0;
        tap = '0;
        chain_scan_sel = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) begin
            #2 tck = 1'b1;
            #3 tck = 1'b0;
            #1;
        end
    endtask : cyc
    task automatic scan(input logic [7:0] ins, input logic sel, input int len,
                        input logic [35:0] din, output logic [35:0] dout);
        dout = '0;
        tap.instr = ins;
        chain_scan_sel = sel;
        tap.capture_dr = ~sel;
        cyc(1);
        tap.capture_dr = 1'b0;
        tap.shift_dr = 1'b1;
        for (int i = 0; i < len; i++) begin
            dout[i] = tdo_o;
            tap.tdi = din[i];
            cyc(1);
        end
        tap.shift_dr = 1'b0;
        tap.update_dr = 1'b1;
        cyc(1);
        tap.update_dr = 1'b0;
        chain_scan_sel = 1'b0;
        // Stale data would hide a late sample
        tap.tdi = ~tap.tdi;
    endtask : scan
    task automatic run(input int n);
        tap.instr = brte_pkg::INSTR_RUN_TEST;
        cyc(3);
        tap.run_idle = 1'b1;
        cyc(n);
        tap.run_idle = 1'b0;
        cyc(8);
    endtask : run
endmodule : brte_ctlr_model

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b0;
    logic tck, chain_scan_sel, tdo_o, run_active_o, ctrl_update_o;
    logic a_pin_oe, b_pin_oe;
    logic [7:0] a_pin_o, b_pin_o, core_a_o, core_b_o;
    logic [7:0] a_ext = 8'h5a;
    logic [7:0] b_ext = 8'hc3;
    wire logic [7:0] a_pin = a_pin_oe ? a_pin_o : a_ext;
    wire logic [7:0] b_pin = b_pin_oe ? b_pin_o : b_ext;
    brte_pkg::brte_tap_s tap;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [10:0] rc [11] = '{11'h000, 11'h004, 11'h001, 11'h07a, 11'h005,
        11'h40e, 11'h003, 11'h007, 11'h1e7, 11'h001, 11'h001};
    logic [35:0] sd [11] = '{36'h8_1122_3344, 36'h4_1122_3344,
        36'h8_1122_3344, 36'h8_1122_3344, 36'h4_1122_3344, 36'h4_1122_3344,
        36'h8_1122_3344, 36'h8_1122_33fe, 36'h4_1122_ff33, 36'h0_1122_3344,
        36'h8_0000_0000};
    int rn [11] = '{3, 3, 5, 4, 5, 4, 6, 3, 2, 4, 4};

    brte_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tck(tck),
        .tap(tap), .chain_scan_sel(chain_scan_sel), .a_pin_i(a_pin),
        .b_pin_i(b_pin), .a_pin_o(a_pin_o), .a_pin_oe(a_pin_oe),
        .b_pin_o(b_pin_o), .b_pin_oe(b_pin_oe), .core_a_o(core_a_o),
        .core_b_o(core_b_o), .tdo_o(tdo_o), .run_active_o(run_active_o),
        .ctrl_update_o(ctrl_update_o));
    brte_ctlr_model ctl_u (.tck(tck), .tap(tap),
        .chain_scan_sel(chain_scan_sel), .tdo_o(tdo_o));

    always #5 clk_sys = ~clk_sys;

    function automatic logic [15:0] lf16(input logic [15:0] v);
        return {v[14:0], ^(v & brte_pkg::TAP16_DEFAULT)};
    endfunction : lf16
    function automatic logic [7:0] lf8(input logic [7:0] v);
        return {v[6:0], ^(v & brte_pkg::TAP8_DEFAULT)};
    endfunction : lf8
    // One run step of the cell chain
    function automatic brte_pkg::brte_cells_s nx(
        input brte_pkg::brte_cells_s c, input logic [10:0] r);
        logic ab;
        logic [7:0] s, d, o, p, m;
        logic [15:0] v;
        ab = c.ctl[3];
        s = ab ? c.a_in : c.b_in;
        d = ab ? c.b_out : c.a_out;
        o = ab ? c.a_out : c.b_out;
        p = ab ? a_ext : b_ext;
        m = p & ~r[10:3];
        if (r[1:0] == 2'h3) begin
            s = lf8(s) ^ m;
            o = r[2] ? o + 8'(d == 8'hff) : o;
            d = r[2] ? d + 8'h01 : lf8(d);
        end else if (r[1:0] == 2'h0) begin
            s = p;
            d = ~d;
        end else begin
            v = lf16({s, d});
            v[15:8] = r[1] ? v[15:8] ^ m : v[15:8];
            {s, d} = v;
        end
        if (ab) {c.a_in, c.b_out, c.a_out} = {s, d, o};
        else {c.b_in, c.a_out, c.b_out} = {s, d, o};
        return c;
    endfunction : nx

    task automatic chk(input logic [35:0] g, input logic [35:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic final_report;
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        brte_pkg::brte_cells_s e, sh;
        logic [35:0] d;
        logic [10:0] pc;
        fork
            ctl_u.cyc(20);
            repeat (12) @(negedge clk_sys);
        join
        rst_n = 1'b1;
        ce = 1'b1;
        ctl_u.cyc(8);
        e = brte_pkg::CELLS_RESET;
        sh = e;
        pc = brte_pkg::CTRL_RESET;
        for (int i = 0; i < 11; i++) begin
            ctl_u.scan(i[0] ? brte_pkg::INSTR_CTRL_SCAN_TEST
                : brte_pkg::INSTR_CTRL_SCAN_NORMAL, 1'b0, 11, 36'(rc[i]), d);
            chk(d, 36'(pc));
            pc = rc[i];
            ctl_u.scan(8'h03, 1'b1, 36, sd[i], d);
            chk(d, e);
            e = sd[i];
            ctl_u.run(rn[i]);
            chk(36'({~e.ctl[3], ~e.ctl[2]}), 36'({a_pin_oe, b_pin_oe}));
            if (e.ctl[3] != e.ctl[2]) begin
                repeat (rn[i]) e = nx(e, rc[i]);
                {sh.a_in, sh.b_in} = {e.a_in, e.b_in};
                // Signature16 mode keeps output shadows
                if (rc[i][1:0] != 2'h2) {sh.a_out, sh.b_out} = {e.a_out, e.b_out};
                if (e.ctl[3]) chk(36'({b_pin_o, core_a_o}), 36'({sh.b_out, sh.a_in}));
                else chk(36'({a_pin_o, core_b_o}), 36'({sh.a_out, sh.b_in}));
            end
            $display("row %0d done", i);
        end
        ctl_u.scan(8'h03, 1'b1, 36, 36'h0, d);
        chk(d, e);
        final_report();
    end
endmodule : tb
